// ---- src/sensor_diag_status.sv ----
/*
 * Status and diagnostic bytes of a chained safety sensor. Encodes output,
 * actuator, input and limit state plus fault causes into the response and
 * warning/error bytes, latches errors, handles the error reset request and
 * switches the safety outputs off on error or on a long-standing warning, except while the link fault flag holds them.
 * Assumes sensor pins are asynchronous and the request byte and link
 * fault flag come from the serial link logic on the same clock.
 */
`timescale 1ns/1ps
module sensor_diag_status
   import sdiag_pkg::*;
#(
   parameter logic [TMR_W-1:0] WARN_CYCLES = WARN_TIMEOUT_CYC[TMR_W-1:0]
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Sensor pins, asynchronous
   input wire logic SAFETY_INPUT_A,
   input wire logic SAFETY_INPUT_B,
   input wire logic ACTUATOR_PRESENT,
   input wire logic ACTUATOR_IN_LIMIT,
   input wire logic ACTUATOR_BAD,
   input wire logic FAULT_OUT_A,
   input wire logic FAULT_OUT_B,
   input wire logic CROSS_WIRE,
   input wire logic OVER_TEMP,
   input wire logic INTERNAL_FAULT,
   // Serial link side, same clock
   input wire logic [7:0] REQUEST_BYTE,
   input wire logic REQUEST_VALID,
   input wire logic COMM_FAULT,
   output logic [7:0] RESPONSE_BYTE,
   output logic [7:0] WARNING_ERROR_BYTE,
   // Safety output enables
   output logic SAFETY_OUTPUT_A,
   output logic SAFETY_OUTPUT_B
);
   logic [PIN_W-1:0] pins; // Raw pin vector
   logic [PIN_W-1:0] meta_r; // First synchroniser stage, read by sync_r only
   logic [PIN_W-1:0] sync_r; // Synchronised pins
   logic req7_r; // Last seen error reset bit
   logic req_fall; // Error reset bit fell from one to zero
   logic act_prev_r; // Actuator state a cycle ago
   logic guard_open; // Actuator has just left, the guard was opened
   logic release_ev; // Guard closed again, outputs may release
   logic [3:0] ofault_r; // Latched output-side faults
   logic [3:0] ofault_nxt;
   logic err_r; // Latched error, outputs off
   logic err_nxt;
   logic err_cause; // Live error causes
   logic tmo_r; // Warning delay ran out
   logic warn; // Error warning present
   logic out_en_r; // Safety outputs enabled
   logic out_en_nxt;
   logic [7:0] rsp_r; // Response byte
   logic [7:0] diag_r; // Warning/error byte
   logic [7:0] diag_nxt;

   warn_timer_if tif ();

   // Pin vector, assembled once so the synchroniser is one register pair
   assign pins[PIN_IN_A] = SAFETY_INPUT_A;
   assign pins[PIN_IN_B] = SAFETY_INPUT_B;
   assign pins[PIN_ACT] = ACTUATOR_PRESENT;
   assign pins[PIN_LIMIT] = ACTUATOR_IN_LIMIT;
   assign pins[PIN_ACT_BAD] = ACTUATOR_BAD;
   assign pins[PIN_FLT_A] = FAULT_OUT_A;
   assign pins[PIN_FLT_B] = FAULT_OUT_B;
   assign pins[PIN_CROSS] = CROSS_WIRE;
   assign pins[PIN_TEMP] = OVER_TEMP;
   assign pins[PIN_INTERNAL] = INTERNAL_FAULT;

   // Two-stage synchroniser for every sensor pin
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end

   // Edge history of the actuator, used for guard open and release
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         act_prev_r <= 1'b0;
      end else begin
         act_prev_r <= sync_r[PIN_ACT];
      end
   end

   assign guard_open = act_prev_r && !sync_r[PIN_ACT];
   assign release_ev = !act_prev_r && sync_r[PIN_ACT];

   // request decode
   // Only bit 7 is looked at; the remaining request bits carry nothing.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         req7_r <= 1'b0;
      end else if (REQUEST_VALID) begin
         req7_r <= REQUEST_BYTE[REQ_ERR_RESET];
      end
   end

   assign req_fall = REQUEST_VALID && req7_r &&
      !REQUEST_BYTE[REQ_ERR_RESET];

   // output faults latch
   // Output faults cannot be seen to go away while outputs are off, so
   // they are held until the guard closes again; a new fault wins.
   always_comb begin
      ofault_nxt = ofault_r;
      if (release_ev) begin
         ofault_nxt = 4'h0;
      end
      ofault_nxt = ofault_nxt | {sync_r[PIN_TEMP], sync_r[PIN_CROSS],
         sync_r[PIN_FLT_B], sync_r[PIN_FLT_A]};
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ofault_r <= 4'h0;
      end else begin
         ofault_r <= ofault_nxt;
      end
   end

   // Warning: any output-side fault or the link fault; runs the delay timer
   assign warn = |ofault_r || COMM_FAULT;
   assign tif.warn_on = warn && !err_r;

   warn_timer #(
      .CYCLES(WARN_CYCLES)
   ) u_timer (
      .clk(CLK),
      .rst(SYS_RST),
      .tif(tif)
   );

   // timeout latch
   // Cleared together with the error so a fresh warning restarts it.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         tmo_r <= 1'b0;
      end else if (tif.expired) begin
         tmo_r <= 1'b1;
      end else if (!err_r) begin
         tmo_r <= 1'b0;
      end
   end

   assign err_cause = sync_r[PIN_ACT_BAD] || sync_r[PIN_INTERNAL] ||
      tif.expired || (tmo_r && warn);

   // error latch
   // A cause present in the clearing cycle keeps the error set.
   always_comb begin
      err_nxt = err_r;
      if (!err_cause && (req_fall || guard_open)) begin
         err_nxt = 1'b0;
      end
      if (err_cause) begin
         err_nxt = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         err_r <= 1'b0;
      end else begin
         err_r <= err_nxt;
      end
   end

   // output hold
   // While the link is down the enable keeps its last value; this trades
   // reaction to the guard for stability as the behaviour demands.
   always_comb begin
      out_en_nxt = out_en_r;
      if (!COMM_FAULT) begin
         out_en_nxt = sync_r[PIN_ACT] && sync_r[PIN_IN_A] &&
            sync_r[PIN_IN_B] && !err_r;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         out_en_r <= 1'b0;
      end else begin
         out_en_r <= out_en_nxt;
      end
   end

   assign SAFETY_OUTPUT_A = out_en_r;
   assign SAFETY_OUTPUT_B = out_en_r;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rsp_r <= BYTE_RST;
      end else begin
         rsp_r <= BYTE_RST;
         rsp_r[RSP_OUT_EN] <= out_en_r;
         rsp_r[RSP_ACT] <= sync_r[PIN_ACT];
         rsp_r[RSP_INPUTS] <= sync_r[PIN_IN_A] && sync_r[PIN_IN_B];
         rsp_r[RSP_LIMIT] <= sync_r[PIN_ACT] && sync_r[PIN_LIMIT];
         rsp_r[RSP_WARN] <= warn;
         rsp_r[RSP_ERR] <= err_r;
      end
   end

   always_comb begin
      diag_nxt = BYTE_RST;
      diag_nxt[DG_TEMP:DG_OUT_A] = ofault_r;
      diag_nxt[DG_INTERNAL] = sync_r[PIN_INTERNAL];
      if (err_r) begin
         diag_nxt[DG_ACT_BAD] = sync_r[PIN_ACT_BAD];
      end else begin
         diag_nxt[DG_COMM] = COMM_FAULT;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         diag_r <= BYTE_RST;
      end else begin
         diag_r <= diag_nxt;
      end
   end

   assign RESPONSE_BYTE = rsp_r;
   assign WARNING_ERROR_BYTE = diag_r;

   // Checks on the encoding and the error handling
   sequence s_reset_fall;
      REQUEST_VALID && req7_r && !REQUEST_BYTE[REQ_ERR_RESET];
   endsequence

   sequence s_quiet_clear;
      err_r && !err_cause ##0 s_reset_fall;
   endsequence

   a_err_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_quiet_clear |=> !err_r)
      else $error("error not cleared by reset request");
   a_diag_error: assert property (@(posedge CLK) disable iff (SYS_RST)
      err_r |=> diag_r[DG_ACT_BAD] == $past(sync_r[PIN_ACT_BAD])
         && !diag_r[DG_COMM])
      else $error("error form of diagnostic byte wrong");
   a_fault_bits: assert property (@(posedge CLK) disable iff (SYS_RST)
      sync_r[PIN_FLT_A] && sync_r[PIN_CROSS] ##1 1'b1
         |=> diag_r[DG_OUT_A] && diag_r[DG_CROSS])
      else $error("output fault bits not combined");
   a_input_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
      ##1 rsp_r[RSP_INPUTS] == $past(sync_r[PIN_IN_A] &&
         sync_r[PIN_IN_B]))
      else $error("input bit mismatch");
   a_limit_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
      rsp_r[RSP_LIMIT] |-> rsp_r[RSP_ACT])
      else $error("limit bit without actuator");
   a_comm_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
      COMM_FAULT && !err_r |=> diag_r[DG_COMM] && rsp_r[RSP_WARN])
      else $error("link fault not reported");
   a_comm_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      COMM_FAULT |=> out_en_r == $past(out_en_r))
      else $error("outputs changed during link fault");
   a_err_off: assert property (@(posedge CLK) disable iff (SYS_RST)
      err_r && !COMM_FAULT |=> !out_en_r ##1 !rsp_r[RSP_OUT_EN])
      else $error("outputs stay on under error");
   a_timeout_err: assert property (@(posedge CLK) disable iff (SYS_RST)
      tif.expired |=> err_r)
      else $error("warning timeout did not raise error");
   a_error_shown: assert property (@(posedge CLK) disable iff (SYS_RST)
      err_r |=> rsp_r[RSP_ERR])
      else $error("error not shown in response byte");
endmodule

// ---- src/sdiag_pkg.sv ----
/*
 * Constants for the status and diagnostic byte logic of a chained safety
 * sensor: bit positions of the three bytes, pin vector layout, timing.
 * Assumes a single 125 MHz clock and a synchronous active-high reset.
 */
package sdiag_pkg;
   // Response byte bit positions
   localparam int RSP_OUT_EN = 0;
   localparam int RSP_ACT = 1;
   localparam int RSP_INPUTS = 4;
   localparam int RSP_LIMIT = 5;
   localparam int RSP_WARN = 6;
   localparam int RSP_ERR = 7;
   // Diagnostic byte bit positions
   localparam int DG_OUT_A = 0;
   localparam int DG_OUT_B = 1;
   localparam int DG_CROSS = 2;
   localparam int DG_TEMP = 3;
   localparam int DG_ACT_BAD = 4;
   localparam int DG_INTERNAL = 5;
   localparam int DG_COMM = 6;
   // Request byte: error reset bit
   localparam int REQ_ERR_RESET = 7;
   // Pin vector layout, all pins pass the synchroniser
   localparam int PIN_IN_A = 0;
   localparam int PIN_IN_B = 1;
   localparam int PIN_ACT = 2;
   localparam int PIN_LIMIT = 3;
   localparam int PIN_ACT_BAD = 4;
   localparam int PIN_FLT_A = 5;
   localparam int PIN_FLT_B = 6;
   localparam int PIN_CROSS = 7;
   localparam int PIN_TEMP = 8;
   localparam int PIN_INTERNAL = 9;
   localparam int PIN_W = 10;
   // Byte reset value
   localparam logic [7:0] BYTE_RST = 8'h00;
   // Timing of the warning switch-off delay
   localparam longint unsigned CLK_PERIOD_NS = 8;
   localparam longint unsigned WARN_TIMEOUT_MIN = 30;
   localparam longint unsigned WARN_TIMEOUT_CYC =
      WARN_TIMEOUT_MIN * 60 * 1000000000 / CLK_PERIOD_NS;
   localparam int TMR_W = 38;
   localparam logic [TMR_W-1:0] TMR_ZERO = 38'h0;
   localparam logic [TMR_W-1:0] TMR_ONE = 38'h1;
endpackage

// ---- src/warn_timer_if.sv ----
/*
 * Carrier between the status logic and the warning delay timer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface warn_timer_if;
   logic warn_on; // Warning condition present, timer runs while high
   logic expired; // Level, delay has run out
   modport owner (output warn_on, input expired);
   modport timer (input warn_on, output expired);
endinterface

// ---- src/warn_timer.sv ----
/*
 * Delay timer for the error warning: counts while the warning stands and
 * flags expiry once the full delay has passed without rectification.
 * Assumes warn_on comes from logic on the same clock.
 */
`timescale 1ns/1ps
module warn_timer
   import sdiag_pkg::*;
#(
   parameter logic [TMR_W-1:0] CYCLES = WARN_TIMEOUT_CYC[TMR_W-1:0]
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Owner side
   warn_timer_if.timer tif
);
   logic [TMR_W-1:0] cnt_r; // Cycles the warning has stood so far
   logic exp_r; // Expiry flag

   // delay count
   // Restarts whenever the warning drops, so only an unbroken warning
   // reaches expiry; the count saturates at the limit.
   always_ff @(posedge clk) begin
      if (rst || !tif.warn_on) begin
         cnt_r <= TMR_ZERO;
      end else if (cnt_r != CYCLES) begin
         cnt_r <= cnt_r + TMR_ONE;
      end
   end

   // Expiry level, registered for a clean output
   always_ff @(posedge clk) begin
      if (rst) begin
         exp_r <= 1'b0;
      end else begin
         exp_r <= tif.warn_on && (cnt_r == CYCLES - TMR_ONE ||
            cnt_r == CYCLES);
      end
   end

   assign tif.expired = exp_r;

   // Expiry rises only after a cycle with the warning present
   a_expiry_cause: assert property (@(posedge clk) disable iff (rst)
      $rose(exp_r) |-> $past(tif.warn_on))
      else $error("warning expiry without warning");
endmodule

// ---- verif/gateway_model.sv ----
/*
 * Gateway-side model: issues request bytes and raises the link fault flag.
 * Assumes the sensor block samples requests on the rising clock edge.
 */
`timescale 1ns/1ps
module gateway_model (
   // Clock
   input wire logic clk,
   // Link outputs toward the sensor
   output logic [7:0] req_byte,
   output logic req_valid,
   output logic comm_fault
);
   // Quiet link at time zero
   initial begin
      req_byte = 8'h00;
      req_valid = 1'b0;
      comm_fault = 1'b0;
   end

   // reset request bit
   // Unused bits carry filler so a decoder leaning on them shows up
   task automatic send(input logic bit7, input int gap);
      @(posedge clk);
      #1;
      req_byte = {bit7, 7'h55};
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      // Stale byte inverted once the strobe is gone
      req_byte = ~req_byte;
      repeat (gap) @(posedge clk);
      // Step off the edge so callers never sample a launching edge
      #1;
   endtask

   // Link fault level, changed just after an edge
   task automatic link(input logic f);
      @(posedge clk);
      #1;
      comm_fault = f;
   endtask
endmodule

// ---- verif/sensor_diag_status_test.sv ----
/*
 * Self-checking bench for the status and diagnostic byte logic.
 * Assumes a short warning delay parameter and the gateway model beside it.
 */
`timescale 1ns/1ps
module sensor_diag_status_test;
   import sdiag_pkg::*;
   // Short delay keeps the run brief
   localparam logic [TMR_W-1:0] WCYC = 38'h28;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [PIN_W-1:0] pin = '0; // Sensor pin vector
   logic [7:0] req_byte, rsp, diag;
   logic req_valid, comm_fault, out_a, out_b;
   int mismatches = 0;
   int samples_checked = 0;

   // Clock, 8 ns period
   initial begin
      forever #4 clk = ~clk;
   end

   gateway_model gw_u (.clk(clk), .req_byte(req_byte),
      .req_valid(req_valid), .comm_fault(comm_fault));

   sensor_diag_status #(.WARN_CYCLES(WCYC)) dut_u (.CLK(clk),
      .SYS_RST(rst), .SAFETY_INPUT_A(pin[PIN_IN_A]),
      .SAFETY_INPUT_B(pin[PIN_IN_B]), .ACTUATOR_PRESENT(pin[PIN_ACT]),
      .ACTUATOR_IN_LIMIT(pin[PIN_LIMIT]), .ACTUATOR_BAD(pin[PIN_ACT_BAD]),
      .FAULT_OUT_A(pin[PIN_FLT_A]), .FAULT_OUT_B(pin[PIN_FLT_B]),
      .CROSS_WIRE(pin[PIN_CROSS]), .OVER_TEMP(pin[PIN_TEMP]),
      .INTERNAL_FAULT(pin[PIN_INTERNAL]), .REQUEST_BYTE(req_byte),
      .REQUEST_VALID(req_valid), .COMM_FAULT(comm_fault),
      .RESPONSE_BYTE(rsp), .WARNING_ERROR_BYTE(diag),
      .SAFETY_OUTPUT_A(out_a), .SAFETY_OUTPUT_B(out_b));

   // Byte comparison
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Output pair comparison
   task automatic chk_out(input logic exp);
      chk8({6'h00, out_a, out_b}, {6'h00, exp, exp});
   endtask

   // Drive one pin just after an edge
   task automatic setp(input int idx, input logic v);
      @(posedge clk);
      #1;
      pin[idx] = v;
   endtask

   // Pins pass two sync stages plus output registers
   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask

   // Inputs live, actuator, limit range
   task automatic t_run();
      setp(PIN_IN_A, 1'b1);
      setp(PIN_IN_B, 1'b1);
      settle();
      chk8(rsp, 8'h10);
      chk_out(1'b0);
      setp(PIN_ACT, 1'b1);
      settle();
      chk8(rsp, 8'h13);
      chk_out(1'b1);
      setp(PIN_LIMIT, 1'b1);
      settle();
      chk8(rsp, 8'h33);
      chk_out(1'b1);
      setp(PIN_LIMIT, 1'b0);
   endtask

   // Hard errors: refused clear, request clear, guard clear
   task automatic t_error();
      setp(PIN_INTERNAL, 1'b1);
      settle();
      chk8(rsp, 8'h92);
      chk8(diag, 8'h20);
      chk_out(1'b0);
      gw_u.send(1'b1, 0);
      gw_u.send(1'b0, 4);
      chk8(rsp, 8'h92);
      setp(PIN_INTERNAL, 1'b0);
      settle();
      gw_u.send(1'b1, 0);
      gw_u.send(1'b0, 4);
      chk8(rsp, 8'h13);
      setp(PIN_ACT_BAD, 1'b1);
      settle();
      chk8(diag, 8'h10);
      setp(PIN_ACT_BAD, 1'b0);
      setp(PIN_ACT, 1'b0);
      settle();
      chk8(rsp, 8'h10);
      setp(PIN_ACT, 1'b1);
      settle();
   endtask

   // Latched output faults, then the warning delay runs out
   task automatic t_warn();
      setp(PIN_FLT_A, 1'b1);
      setp(PIN_FLT_B, 1'b1);
      setp(PIN_CROSS, 1'b1);
      setp(PIN_TEMP, 1'b1);
      pin[PIN_FLT_B] = 1'b0;
      pin[PIN_FLT_A] = 1'b0;
      setp(PIN_CROSS, 1'b0);
      pin[PIN_TEMP] = 1'b0;
      settle();
      chk8(diag, 8'h0f);
      chk8(rsp, 8'h53);
      chk_out(1'b1);
      repeat (60) @(posedge clk);
      #1;
      chk8(rsp, 8'hd2);
      chk_out(1'b0);
      setp(PIN_ACT, 1'b0);
      settle();
      setp(PIN_ACT, 1'b1);
      settle();
      chk8(rsp, 8'h92);
      gw_u.send(1'b1, 0);
      gw_u.send(1'b0, 4);
      chk8(rsp, 8'h13);
   endtask

   // Link fault holds the outputs while the guard opens
   task automatic t_comm();
      gw_u.link(1'b1);
      settle();
      chk8(diag, 8'h40);
      chk8(rsp, 8'h53);
      setp(PIN_ACT, 1'b0);
      settle();
      chk_out(1'b1);
      gw_u.link(1'b0);
      settle();
      chk_out(1'b0);
      chk8(rsp, 8'h10);
   endtask

   // Verdict and end of run
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog, well beyond the expected run
   initial begin
      #40000;
      mismatches++;
      conclude();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      #1;
      chk8(rsp, 8'h00);
      chk_out(1'b0);
      rst = 1'b0;
      t_run();
      t_error();
      t_warn();
      t_comm();
      conclude();
   end
endmodule
